// ===== carrier_map.svh
// register offsets, field positions and reset values of the carrier block
// Overview of operation
// - rising sequence starts at the rising start level, reset FF80h
// - falling sequence starts at the falling start level, reset 4000h
// - rising sequence ends once carrier passes rising end level, reset 3F7Dh
// - falling sequence ends once carrier passes falling end level, reset 0003h
// - rising sequence begins with rising initial increment, reset 020Ch
// - falling sequence begins with falling initial increment, reset FDF4h
// - rising increment changes each step by rising increment change, reset 0
// - falling increment changes each step by falling increment change, reset 0
// - at start the carrier takes the power-on carrier value, reset FF80h
// - at start the increment takes the power-on increment value, reset 020Ch
// - reload bit 0: only the increment reloads at a threshold
// - reload bit 1: carrier and increment both reload at a threshold
// - single-pulse bit 1: at most one rise and one fall per period
// - reference select 0: fixed level subtracted from loop-filter input
// - reference select 1: carrier subtracted from loop-filter input
// - reset values give a 768 kHz triangle between 0 and 1
// - first sequence direction follows the initial direction bit
`ifndef CARRIER_MAP_SVH
`define CARRIER_MAP_SVH
`define IDX_RISE_START     8'h2B
`define IDX_FALL_START     8'h2C
`define IDX_RISE_END       8'h2D
`define IDX_FALL_END       8'h2E
`define IDX_RISE_INC       8'h2F
`define IDX_FALL_INC       8'h30
`define IDX_RISE_CHG       8'h31
`define IDX_FALL_CHG       8'h32
`define IDX_CARR_PON       8'h33
`define IDX_INC_PON        8'h34
`define IDX_CONTROL        8'h35
`define IDX_FIXED_LEVEL    8'h36
`define IDX_RUN            8'h37
`define IDX_STATUS         8'h38
`define RST_RISE_START     16'hFF80
`define RST_FALL_START     16'h4000
`define RST_RISE_END       16'h3F7D
`define RST_FALL_END       16'h0003
`define RST_RISE_INC       16'h020C
`define RST_FALL_INC       16'hFDF4
`define RST_RISE_CHG       16'h0000
`define RST_FALL_CHG       16'h0000
`define RST_CARR_PON       16'hFF80
`define RST_INC_PON        16'h020C
`define RST_CONTROL        5'h1A
`define RST_FIXED_LEVEL    16'h0000
`define CTL_START_RISE     0
`define CTL_REF_CARRIER    1
`define CTL_FLIP           2
`define CTL_SINGLE         3
`define CTL_RELOAD         4
`define CTL_W              5
`define SAMPLE_HZ          49152000
`define CLK_HZ             25000000
`endif

// ===== carrier_pkg.sv
// types shared by the carrier block
package carrier_pkg;
   typedef enum logic {SEQ_RISE, SEQ_FALL} seq_t;
   typedef struct packed {
      logic [15:0] rise_start_level;
      logic [15:0] fall_start_level;
      logic [15:0] rise_end_level;
      logic [15:0] fall_end_level;
      logic [15:0] rise_initial_increment;
      logic [15:0] fall_initial_increment;
      logic [15:0] rise_increment_change;
      logic [15:0] fall_increment_change;
      logic [15:0] carrier_power_on_value;
      logic [15:0] increment_power_on_value;
      logic [4:0]  pwm_output_control;
      logic [15:0] fixed_level;
      logic        run;
   } regs_t;
   typedef struct packed {
      regs_t       r;
      seq_t        seq;
      logic        started;
      logic [15:0] carrier;
      logic [15:0] increment;
      logic        pwm;
      logic        rose;
      logic        fell;
      logic [31:0] prdata;
   } state_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
endpackage

// ===== pwm_carrier_comparator.sv
// carrier generator and comparator with apb register bank
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "carrier_map.svh"
module pwm_carrier_comparator (
   input  wire logic                  pclk,        // 25 MHz clock
   input  wire logic                  presetn,     // async reset, active low
   input  wire carrier_pkg::apb_req_t apb,         // apb request
   output logic [31:0]                prdata,      // read data
   output logic                       pready,      // always ready
   output logic                       pslverr,     // unmapped access
   input  wire logic                  sample_en,   // one-cycle sample strobe
   input  wire logic [15:0]           loop_in,     // loop-filter output, Q1.14
   output logic                       pwm_out,     // pwm toward power stage
   output logic                       period_mark  // pulse at each fall-to-rise turnaround
);
   carrier_pkg::state_t s_q, s_d;
   logic [9:0]  idx;
   logic        mapped, wr, rd;
   logic [16:0] nxt_carr, diff;
   logic [15:0] nxt_inc, ref_lvl;
   logic        passed, want;

   assign idx = apb.paddr[11:2];
   assign mapped = (idx >= 10'(`IDX_RISE_START)) && (idx <= 10'(`IDX_STATUS));
   assign wr = apb.psel && apb.penable && apb.pwrite;
   assign rd = apb.psel && !apb.penable && !apb.pwrite;
   assign pready = 1'b1;
   assign pslverr = apb.psel && apb.penable && !mapped;
   assign prdata = s_q.prdata;
   assign pwm_out = s_q.pwm;

   always_comb begin
      s_d = s_q;
      period_mark = 1'b0;
      nxt_carr = 17'($signed(s_q.carrier)) + 17'($signed(s_q.increment));
      passed = 1'b0;
      // wrap-safe threshold test on the widened sum
      if (s_q.seq == carrier_pkg::SEQ_RISE)
         passed = $signed(nxt_carr) > $signed({s_q.r.rise_end_level[15], s_q.r.rise_end_level});
      else
         passed = $signed(nxt_carr) < $signed({s_q.r.fall_end_level[15], s_q.r.fall_end_level});
      nxt_inc = s_q.increment + ((s_q.seq == carrier_pkg::SEQ_RISE) ?
                s_q.r.rise_increment_change : s_q.r.fall_increment_change);
      ref_lvl = s_q.r.pwm_output_control[`CTL_REF_CARRIER] ? s_q.carrier
                : s_q.r.fixed_level;
      // widened so that far-apart operands cannot flip the sign
      diff = {loop_in[15], loop_in} - {ref_lvl[15], ref_lvl};
      want = !diff[16] && (diff != 17'h00000);
      want = want ^ s_q.r.pwm_output_control[`CTL_FLIP];
      if (!s_q.r.run) begin
         s_d.started = 1'b0;
      end else if (!s_q.started) begin
         s_d.started = 1'b1;
         s_d.carrier = s_q.r.carrier_power_on_value;
         s_d.increment = s_q.r.increment_power_on_value;
         s_d.seq = s_q.r.pwm_output_control[`CTL_START_RISE] ? carrier_pkg::SEQ_RISE
                   : carrier_pkg::SEQ_FALL;
         s_d.rose = 1'b0;
         s_d.fell = 1'b0;
      end else if (sample_en) begin
         if (passed) begin
            if (s_q.seq == carrier_pkg::SEQ_RISE) begin
               s_d.seq = carrier_pkg::SEQ_FALL;
               s_d.increment = s_q.r.fall_initial_increment;
               if (s_q.r.pwm_output_control[`CTL_RELOAD])
                  s_d.carrier = s_q.r.fall_start_level;
               else
                  s_d.carrier = nxt_carr[15:0];
            end else begin
               s_d.seq = carrier_pkg::SEQ_RISE;
               s_d.increment = s_q.r.rise_initial_increment;
               if (s_q.r.pwm_output_control[`CTL_RELOAD])
                  s_d.carrier = s_q.r.rise_start_level;
               else
                  s_d.carrier = nxt_carr[15:0];
               s_d.rose = 1'b0;
               s_d.fell = 1'b0;
               period_mark = 1'b1;
            end
         end else begin
            s_d.carrier = nxt_carr[15:0];
            s_d.increment = nxt_inc;
         end
      end
      // output edges; single-pulse mode allows one of each per period
      if (want != s_q.pwm) begin
         if (!s_q.r.pwm_output_control[`CTL_SINGLE]) begin
            s_d.pwm = want;
         end else if (want && !(s_q.rose && !period_mark)) begin
            s_d.pwm = 1'b1;
            s_d.rose = 1'b1;
         end else if (!want && !(s_q.fell && !period_mark)) begin
            s_d.pwm = 1'b0;
            s_d.fell = 1'b1;
         end
      end
      if (wr && mapped) begin
         case (idx[7:0])
            `IDX_RISE_START:  s_d.r.rise_start_level = apb.pwdata[15:0];
            `IDX_FALL_START:  s_d.r.fall_start_level = apb.pwdata[15:0];
            `IDX_RISE_END:    s_d.r.rise_end_level = apb.pwdata[15:0];
            `IDX_FALL_END:    s_d.r.fall_end_level = apb.pwdata[15:0];
            `IDX_RISE_INC:    s_d.r.rise_initial_increment = apb.pwdata[15:0];
            `IDX_FALL_INC:    s_d.r.fall_initial_increment = apb.pwdata[15:0];
            `IDX_RISE_CHG:    s_d.r.rise_increment_change = apb.pwdata[15:0];
            `IDX_FALL_CHG:    s_d.r.fall_increment_change = apb.pwdata[15:0];
            `IDX_CARR_PON:    s_d.r.carrier_power_on_value = apb.pwdata[15:0];
            `IDX_INC_PON:     s_d.r.increment_power_on_value = apb.pwdata[15:0];
            `IDX_CONTROL:     s_d.r.pwm_output_control = apb.pwdata[`CTL_W-1:0];
            `IDX_FIXED_LEVEL: s_d.r.fixed_level = apb.pwdata[15:0];
            `IDX_RUN:         s_d.r.run = apb.pwdata[0];
            default:          s_d.r = s_q.r;
         endcase
      end
      if (rd) begin
         // unmapped indices alias onto mapped low bytes, so force them to default
         case (mapped ? idx[7:0] : 8'h00)
            `IDX_RISE_START:  s_d.prdata = {16'h0000, s_q.r.rise_start_level};
            `IDX_FALL_START:  s_d.prdata = {16'h0000, s_q.r.fall_start_level};
            `IDX_RISE_END:    s_d.prdata = {16'h0000, s_q.r.rise_end_level};
            `IDX_FALL_END:    s_d.prdata = {16'h0000, s_q.r.fall_end_level};
            `IDX_RISE_INC:    s_d.prdata = {16'h0000, s_q.r.rise_initial_increment};
            `IDX_FALL_INC:    s_d.prdata = {16'h0000, s_q.r.fall_initial_increment};
            `IDX_RISE_CHG:    s_d.prdata = {16'h0000, s_q.r.rise_increment_change};
            `IDX_FALL_CHG:    s_d.prdata = {16'h0000, s_q.r.fall_increment_change};
            `IDX_CARR_PON:    s_d.prdata = {16'h0000, s_q.r.carrier_power_on_value};
            `IDX_INC_PON:     s_d.prdata = {16'h0000, s_q.r.increment_power_on_value};
            `IDX_CONTROL:     s_d.prdata = {27'h0000000, s_q.r.pwm_output_control};
            `IDX_FIXED_LEVEL: s_d.prdata = {16'h0000, s_q.r.fixed_level};
            `IDX_RUN:         s_d.prdata = {31'h00000000, s_q.r.run};
            `IDX_STATUS:      s_d.prdata = {s_q.carrier, 13'h0000, s_q.seq == carrier_pkg::SEQ_RISE,
                                            s_q.started, s_q.pwm};
            default:          s_d.prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{r: '{rise_start_level: `RST_RISE_START, fall_start_level: `RST_FALL_START,
                       rise_end_level: `RST_RISE_END, fall_end_level: `RST_FALL_END,
                       rise_initial_increment: `RST_RISE_INC,
                       fall_initial_increment: `RST_FALL_INC,
                       rise_increment_change: `RST_RISE_CHG,
                       fall_increment_change: `RST_FALL_CHG,
                       carrier_power_on_value: `RST_CARR_PON,
                       increment_power_on_value: `RST_INC_PON,
                       pwm_output_control: `RST_CONTROL,
                       fixed_level: `RST_FIXED_LEVEL, run: 1'b0},
                  seq: carrier_pkg::SEQ_RISE, started: 1'b0,
                  carrier: `RST_CARR_PON, increment: `RST_INC_PON,
                  pwm: 1'b0, rose: 1'b0, fell: 1'b0, prdata: 32'h00000000};
      end else begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// ===== power_stage_model.sv
// behavioural power stage: follows the pwm level and counts its switching events
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
   input  wire logic        pclk,      // clock
   input  wire logic        presetn,   // reset, active low
   input  wire logic        pwm_in,    // pwm from the block
   output logic [15:0]      switch_cnt // level changes seen
);
   logic last_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= 1'b0;
         switch_cnt <= 16'h0;
      end else begin
         last_q <= pwm_in;
         if (pwm_in != last_q) begin
            switch_cnt <= switch_cnt + 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== carrier_assertions.sv
// port-level checks of the carrier block
`timescale 1ns/1ps
`default_nettype none
`include "carrier_map.svh"
module carrier_assertions (
   input wire logic                  pclk,       // clock
   input wire logic                  presetn,    // reset, active low
   input wire carrier_pkg::apb_req_t apb,        // apb request
   input wire logic [31:0]           prdata,     // read data
   input wire logic                  pready,     // ready
   input wire logic                  pslverr,    // error
   input wire logic                  sample_en,  // sample strobe
   input wire logic [15:0]           loop_in,    // loop value
   input wire logic                  pwm_out,    // pwm
   input wire logic                  period_mark // period pulse
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [9:0]  idx;
   logic        acc, rd, wr, bad, want, run_q;
   logic [4:0]  ctl_q;
   logic [15:0] fix_q;
   logic [1:0]  rise_q, fall_q;
   assign idx  = apb.paddr[11:2];
   assign acc  = apb.psel && apb.penable && pready;
   assign rd   = acc && !apb.pwrite;
   assign wr   = acc && apb.pwrite;
   assign bad  = apb.paddr[1:0] == 2'h0 &&
                 (idx < 10'(`IDX_RISE_START) || idx > 10'(`IDX_STATUS));
   assign want = ($signed(loop_in) > $signed(fix_q)) ^ ctl_q[`CTL_FLIP];
   // shadows follow the writes; counters restart on any write, a lenient bound
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= `RST_CONTROL;
         fix_q <= `RST_FIXED_LEVEL;
         run_q <= 1'b0;
         rise_q <= 2'h0;
         fall_q <= 2'h0;
      end else begin
         if (wr && idx == 10'(`IDX_CONTROL)) ctl_q <= apb.pwdata[`CTL_W-1:0];
         if (wr && idx == 10'(`IDX_FIXED_LEVEL)) fix_q <= apb.pwdata[15:0];
         if (wr && idx == 10'(`IDX_RUN)) run_q <= apb.pwdata[0];
         if (period_mark || wr || !ctl_q[`CTL_SINGLE]) begin
            rise_q <= 2'h0;
            fall_q <= 2'h0;
         end else begin
            rise_q <= rise_q + {1'b0, $rose(pwm_out)};
            fall_q <= fall_q + {1'b0, $fell(pwm_out)};
         end
      end
   end
   ready_always_a: assert property (pready) else $error("pready low");
   err_phase_a: assert property (pslverr |-> apb.psel && apb.penable)
      else $error("pslverr outside access");
   err_unmapped_a: assert property (acc && bad |-> pslverr) else $error("no pslverr");
   rd_unmapped_a: assert property (rd && bad |-> prdata == 32'h0) else $error("bad read");
   rd_upper_a: assert property (rd && idx >= 10'(`IDX_RISE_START) && idx <= 10'(`IDX_RUN)
      |-> prdata[31:16] == 16'h0)
      else $error("upper bits set");
   ctl_read_a: assert property (rd && idx == 10'(`IDX_CONTROL) |-> prdata[4:0] == ctl_q)
      else $error("control readback");
   fixed_ref_a: assert property (!ctl_q[`CTL_REF_CARRIER] && !ctl_q[`CTL_SINGLE]
      |=> pwm_out == $past(want))
      else $error("fixed level decision");
   mark_strobe_a: assert property (period_mark |-> sample_en)
      else $error("period mark without sample strobe");
   single_rise_a: assert property (rise_q <= 2'h1) else $error("extra rise");
   single_fall_a: assert property (fall_q <= 2'h1) else $error("extra fall");
   mark_idle_a: assert property (!run_q |-> !period_mark) else $error("mark while idle");
endmodule
bind pwm_carrier_comparator carrier_assertions u_carrier_assertions (.pclk(pclk),
   .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sample_en(sample_en), .loop_in(loop_in), .pwm_out(pwm_out), .period_mark(period_mark));
`default_nettype wire

// ===== pwm_carrier_comparator_test.sv
// self-checking bench for the carrier block
`timescale 1ns/1ps
`default_nettype none
`include "carrier_map.svh"
module pwm_carrier_comparator_test;
   localparam logic [32:0] FULL = 33'h1_FFFF_FFFF;
   logic                  pclk, presetn, sample_en, pready, pslverr, pwm_out, period_mark, up;
   carrier_pkg::apb_req_t apb;
   logic [31:0]           prdata, d;
   logic [15:0]           loop_in, switch_cnt, lp, f;
   logic [15:0]           v[0:10];
   logic signed [15:0]    c, i, sum;
   logic [32:0]           exp_q[$], msk_q[$];
   int                    miscompares, checks_done, mark_at, period;
   pwm_carrier_comparator u_pwm_carrier_comparator (.pclk(pclk), .presetn(presetn),
      .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_en(sample_en),
      .loop_in(loop_in), .pwm_out(pwm_out), .period_mark(period_mark));
   power_stage_model u_power_stage_model (.pclk(pclk), .presetn(presetn), .pwm_in(pwm_out),
      .switch_cnt(switch_cnt));
   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && checks_done > 0 && exp_q.size() == 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic xfer(input logic [9:0] idx, input logic w, input logic [31:0] wd,
                       input logic [32:0] e, input logic [32:0] m);
      int t;
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      @(posedge pclk);
      apb <= '{1'b1, 1'b0, w, {idx, 2'h0}, wd};
      @(posedge pclk);
      apb.penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
      if (t >= 50) begin
         miscompares++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      xfer(idx, 1'b1, wd, 33'h0, 33'h1_0000_0000);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [32:0] e, input logic [32:0] m);
      xfer(idx, 1'b0, 32'h0, e, m);
   endtask
   // the result watcher takes the oldest note at every completed transfer
   always @(posedge pclk) begin
      if (apb.psel && apb.penable && pready === 1'b1) begin
         if (exp_q.size() == 0) check("apb", 33'h0, 33'h1);
         else check("apb", {pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      sample_en = 1'b0;
      loop_in = 16'h0;
      apb = '0;
      miscompares = 0;
      checks_done = 0;
      void'($urandom(85913));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      v = '{`RST_RISE_START, `RST_FALL_START, `RST_RISE_END, `RST_FALL_END, `RST_RISE_INC,
            `RST_FALL_INC, `RST_RISE_CHG, `RST_FALL_CHG, `RST_CARR_PON, `RST_INC_PON, `RST_CONTROL};
      for (int j = 0; j < 11; j++) begin
         rd(10'(43 + j), {17'h0, v[j]}, FULL);
      end
      rd(10'h040, {1'b1, 32'h0}, FULL);
      rd(10'h02A, {1'b1, 32'h0}, FULL);
      xfer(10'h3FF, 1'b1, 32'hFFFF_FFFF, 33'h1_0000_0000, 33'h1_0000_0000);
      for (int j = 0; j < 11; j++) begin
         d = $urandom;
         wr(10'(43 + j), d);
         rd(10'(43 + j), {17'h0, j == 10 ? {11'h0, d[4:0]} : d[15:0]}, FULL);
      end
      // fixed level reference, equal values on the last pass
      for (int k = 0; k < 6; k++) begin
         lp = 16'($urandom);
         f = (k == 5) ? lp : 16'($urandom);
         loop_in <= lp;
         wr(10'h036, {16'h0, f});
         wr(10'h035, {27'h0, k[0], 1'b0, k[1], 2'h0});
         repeat (2) @(posedge pclk);
         rd(10'h038, {32'h0, ($signed(lp) > $signed(f)) ^ k[1]}, 33'h1_0000_0001);
      end
      loop_in <= 16'h0200;
      for (int k = 0; k < 8; k++) begin
         v = '{16'h0010, 16'h0400, 16'h0380, 16'h0040, 16'h0040 + 16'($urandom % 64),
               16'hFFD0 - 16'($urandom % 64), 16'($urandom % 16), -16'($urandom % 16),
               16'h0100, 16'h0020, {11'h0, k[0] ^ k[1], k[2], k[1], 1'b1, k[0]}};
         for (int j = 0; j < 11; j++) wr(10'(43 + j), {16'h0, v[j]});
         wr(10'h037, 32'h1);
         repeat (2) @(posedge pclk);
         c = v[8];
         i = v[9];
         up = k[0];
         for (int s = 0; s < 40; s++) begin
            @(posedge pclk);
            sample_en <= 1'b1;
            @(posedge pclk);
            sample_en <= 1'b0;
            repeat (2) @(posedge pclk);
            sum = c + i;
            if (up ? sum > $signed(v[2]) : sum < $signed(v[3])) begin
               c = v[10][4] ? (up ? v[1] : v[0]) : sum;
               i = up ? v[5] : v[4];
               up = !up;
            end else begin
               c = sum;
               i = i + (up ? v[6] : v[7]);
            end
            rd(10'h038, {1'b0, c, 13'h0, up, 1'b1, ($signed(16'h0200) > c) ^ k[1]},
               k[2] ? 33'h1_FFFF_0006 : 33'h1_FFFF_0007);
         end
         wr(10'h037, 32'h0);
      end
      // mid-run reset; reset values alone must give the documented carrier period
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wr(10'(`IDX_RUN), 32'h1);
      mark_at = -1;
      period = 0;
      for (int s = 0; s < 300 && period == 0; s++) begin
         @(posedge pclk);
         sample_en <= 1'b1;
         @(negedge pclk);
         if (period_mark === 1'b1) begin
            if (mark_at >= 0) period = s - mark_at;
            mark_at = s;
         end
         @(posedge pclk);
         sample_en <= 1'b0;
      end
      check("period", 33'(period), 33'(`SAMPLE_HZ / 768000));
      check("switching", {32'h0, switch_cnt != 16'h0}, 33'h1);
      end_sim();
   end
endmodule
`default_nettype wire
